// [rtl/lcd_cfg.svh]
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// slave address: six fixed upper bits, strap gives the lsb
`define LCD_ADDR_HI 6'h1E
// command byte fields
`define LCD_CONT_BIT 7
`define LCD_OP_MODE 2'h2
`define LCD_OP_BANK 5'h1F
`define LCD_OP_DEVSEL 3'h6
`define LCD_OP_ACCESS 3'h7
// highest display ram column and own hardware subaddress
`define LCD_MAX_COLUMN 6'h27
`define LCD_HW_SUBADDR 4'h0
// bit slots of one byte on the wire
`define LCD_LAST_DATA_BIT 4'h7
`define LCD_ACK_SLOT 4'h8
// reset values: blank display, 1:32, character access
`define LCD_RST_MUX 2'h0
`define LCD_RST_DISP 2'h0
`define LCD_RST_ACCESS 2'h0
// sync reset pattern for {scl, sda, toggle, strap}: idle bus high
`define LCD_SYNC_RST 4'hC

`endif

// [rtl/lcd_pkg.sv]
`default_nettype none

package lcd_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_CMD = 6'h04,
        ST_DATA = 6'h08,
        ST_READ = 6'h10,
        ST_SKIP = 6'h20
    } lcd_state_t;

    typedef enum logic [1:0] {
        MUX_1_32 = 2'h0,
        MUX_1_8 = 2'h1,
        MUX_1_16 = 2'h2,
        MUX_1_24 = 2'h3
    } lcd_mux_t;

    typedef enum logic [1:0] {
        DISP_BLANK = 2'h0,
        DISP_NORMAL = 2'h1,
        DISP_ALL_ON = 2'h2,
        DISP_INVERSE = 2'h3
    } lcd_disp_t;

    typedef enum logic [1:0] {
        ACC_CHAR = 2'h0,
        ACC_HALF = 2'h1,
        ACC_FULL = 2'h2,
        ACC_BAD = 2'h3
    } lcd_access_t;

    typedef struct packed {
        lcd_state_t state;
        logic [3:0] bitCnt;
        logic [7:0] rxShift;
        logic [7:0] txShift;
        logic ackPend;
        logic rwBit;
        logic addrHit;
        logic sclLast;
        logic sdaLast;
        logic togLast;
        logic addrLsb;
        logic sdaOut;
        logic sdaOe;
        lcd_mux_t muxRate;
        lcd_disp_t dispStatus;
        logic systemType;
        logic [1:0] topBank;
        logic [3:0] subaddr;
        lcd_access_t accessOrder;
        logic [1:0] ramBank;
        logic [5:0] column;
        logic [7:0] dataByte;
        logic dataStrobe;
        logic readStrobe;
        logic busBusy;
    } lcd_core_t;

endpackage : lcd_pkg

`default_nettype wire

// [rtl/lcd_pin_sync.sv]
`default_nettype none

module lcd_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output wire logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] lvl;
    } lcd_sync_t;

    lcd_sync_t cur;
    lcd_sync_t next_cur;

    // a change is taken only once the second and third stages agree
    always_comb begin
        next_cur = cur;
        next_cur.f1 = d;
        next_cur.f2 = cur.f1;
        next_cur.f3 = cur.f2;
        for (int i = 0; i < W; i++) begin
            if (cur.f2[i] == cur.f3[i]) begin
                next_cur.lvl[i] = cur.f3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= {RST, RST, RST, RST};
        end else begin
            cur <= next_cur;
        end
    end

    assign q = cur.lvl;

endmodule : lcd_pin_sync

`default_nettype wire

// [rtl/lcd_scl_sampler.sv]
`default_nettype none

// link side: sda is taken on the rising serial clock, and a toggle
// tells the core domain that a new bit stands; the bit is held until
// the next rising edge, far longer than the toggle needs to cross
module lcd_scl_sampler (
    input wire logic sclClk,
    input wire logic rst_n,
    input wire logic sdaIn,
    output wire logic sampleBit,
    output wire logic sampleToggle
);

    typedef struct packed {
        logic bitVal;
        logic tog;
    } lcd_smp_t;

    lcd_smp_t cur;
    lcd_smp_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.bitVal = sdaIn;
        next_cur.tog = ~cur.tog;
    end

    always_ff @(posedge sclClk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign sampleBit = cur.bitVal;
    assign sampleToggle = cur.tog;

endmodule : lcd_scl_sampler

`default_nettype wire

// [rtl/lcd_cmd_decoder.sv]
`include "lcd_cfg.svh"
`default_nettype none

module lcd_cmd_decoder (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic slaveAddrStrap,
    input wire logic [7:0] readByte,
    output wire logic sdaOut,
    output wire logic sdaOe,
    output wire logic [1:0] muxRate,
    output wire logic [1:0] dispStatus,
    output wire logic systemType,
    output wire logic [1:0] topBank,
    output wire logic [3:0] subaddr,
    output wire logic [1:0] accessOrder,
    output wire logic [1:0] ramBank,
    output wire logic [5:0] column,
    output wire logic [7:0] dataByte,
    output wire logic dataStrobe,
    output wire logic readStrobe,
    output wire logic busBusy
);

    ////////////////////////////////////////////////////////////////////////////
    // crossing and pin sampling

    logic sampleBit;
    logic sampleToggle;
    logic [3:0] syncLvl;
    logic sclLvl;
    logic sdaLvl;
    logic togLvl;
    logic strapLvl;

    lcd_scl_sampler u_sampler (
        .sclClk(sclClk),
        .rst_n(rst_n),
        .sdaIn(sdaIn),
        .sampleBit(sampleBit),
        .sampleToggle(sampleToggle)
    );

    lcd_pin_sync #(
        .W(4),
        .RST(`LCD_SYNC_RST)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({sclIn, sdaIn, sampleToggle, slaveAddrStrap}),
        .q(syncLvl)
    );

    assign sclLvl = syncLvl[3];
    assign sdaLvl = syncLvl[2];
    assign togLvl = syncLvl[1];
    assign strapLvl = syncLvl[0];

    ////////////////////////////////////////////////////////////////////////////
    // state and events

    lcd_pkg::lcd_core_t cur;
    lcd_pkg::lcd_core_t next_cur;

    logic startEvt;
    logic stopEvt;
    logic sclFall;
    logic sampleEvt;
    logic byteDone;
    logic ackSample;
    logic [7:0] curByte;
    logic storeOk;
    logic cmdEvt;

    function automatic logic lcd_is_bank(input logic [7:0] b);
        return b[6:2] == `LCD_OP_BANK;
    endfunction : lcd_is_bank

    assign startEvt = sclLvl && cur.sclLast && cur.sdaLast && !sdaLvl;
    assign stopEvt = sclLvl && cur.sclLast && !cur.sdaLast && sdaLvl;
    assign sclFall = cur.sclLast && !sclLvl;
    // toggle crossed: the sampled bit has been steady for a while
    assign sampleEvt = (togLvl != cur.togLast) && (cur.state != lcd_pkg::ST_IDLE);
    assign byteDone = sampleEvt && (cur.bitCnt == `LCD_LAST_DATA_BIT);
    assign ackSample = sampleEvt && (cur.bitCnt == `LCD_ACK_SLOT);
    assign curByte = {cur.rxShift[6:0], sampleBit};
    assign cmdEvt = byteDone && (cur.state == lcd_pkg::ST_CMD);
    assign storeOk = cur.systemType && (cur.subaddr == `LCD_HW_SUBADDR);

    always_comb begin
        next_cur = cur;
        next_cur.dataStrobe = 1'b0;
        next_cur.readStrobe = 1'b0;
        next_cur.sclLast = sclLvl;
        next_cur.sdaLast = sdaLvl;
        next_cur.togLast = togLvl;
        // strap is followed only between transfers so an address never shifts mid-frame
        if (cur.state == lcd_pkg::ST_IDLE) begin
            next_cur.addrLsb = strapLvl;
        end

        // ninth slot is the ack bit
        if (ackSample) begin
            next_cur.bitCnt = 4'h0;
            next_cur.ackPend = 1'b0;
            case (cur.state)
                lcd_pkg::ST_ADDR: begin
                    if (!cur.addrHit) begin
                        next_cur.state = lcd_pkg::ST_SKIP;
                    end else if (cur.rwBit) begin
                        next_cur.state = lcd_pkg::ST_READ;
                        next_cur.txShift = readByte;
                        next_cur.readStrobe = 1'b1;
                    end else begin
                        // commands only after a write address
                        next_cur.state = lcd_pkg::ST_CMD;
                    end
                end
                lcd_pkg::ST_READ: begin
                    // nack ends the read, line left released
                    if (sampleBit) begin
                        next_cur.state = lcd_pkg::ST_SKIP;
                    end else begin
                        next_cur.txShift = readByte;
                        next_cur.readStrobe = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (sampleEvt) begin
            next_cur.rxShift = curByte;
            next_cur.bitCnt = cur.bitCnt + 4'h1;
        end

        if (byteDone) begin
            case (cur.state)
                lcd_pkg::ST_ADDR: begin
                    next_cur.addrHit = curByte[7:1] == {`LCD_ADDR_HI, cur.addrLsb};
                    next_cur.rwBit = curByte[0];
                    next_cur.ackPend = curByte[7:1] == {`LCD_ADDR_HI, cur.addrLsb};
                end
                lcd_pkg::ST_CMD: begin
                    next_cur.ackPend = 1'b1;
                    if (lcd_is_bank(curByte)) begin
                        next_cur.topBank = curByte[1:0];
                    end else if (curByte[6:4] == `LCD_OP_ACCESS) begin
                        next_cur.accessOrder = lcd_pkg::lcd_access_t'(curByte[3:2]);
                        next_cur.ramBank = curByte[1:0];
                    end else if (curByte[6:4] == `LCD_OP_DEVSEL) begin
                        next_cur.subaddr = curByte[3:0];
                    end else if (curByte[6:5] == `LCD_OP_MODE) begin
                        next_cur.systemType = curByte[4];
                        next_cur.dispStatus = lcd_pkg::lcd_disp_t'(curByte[3:2]);
                        next_cur.muxRate = lcd_pkg::lcd_mux_t'(curByte[1:0]);
                    end else if (curByte[5:0] <= `LCD_MAX_COLUMN) begin
                        next_cur.column = curByte[5:0];
                    end
                    // continuation bit picks command or data
                    if (!curByte[`LCD_CONT_BIT]) begin
                        next_cur.state = lcd_pkg::ST_DATA;
                    end
                end
                lcd_pkg::ST_DATA: begin
                    // only the addressed device stores and acks
                    if (storeOk) begin
                        next_cur.ackPend = 1'b1;
                        next_cur.dataByte = curByte;
                        next_cur.dataStrobe = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // drive changes only after scl falls or is cleared at start and stop, so sda is otherwise steady while scl is high
        if (sclFall) begin
            if (cur.bitCnt == `LCD_ACK_SLOT) begin
                // pull low through the ack pulse
                // low held until the next falling edge
                next_cur.sdaOe = cur.ackPend;
            end else if (cur.state == lcd_pkg::ST_READ) begin
                next_cur.sdaOe = !cur.txShift[3'h7 - cur.bitCnt[2:0]];
            end else begin
                next_cur.sdaOe = 1'b0;
            end
        end

        // frames open on any start, repeated start included, whatever the state
        if (startEvt) begin
            next_cur.state = lcd_pkg::ST_ADDR;
            next_cur.bitCnt = 4'h0;
            next_cur.ackPend = 1'b0;
            next_cur.sdaOe = 1'b0;
            next_cur.busBusy = 1'b1;
        end else if (stopEvt) begin
            next_cur.state = lcd_pkg::ST_IDLE;
            next_cur.bitCnt = 4'h0;
            next_cur.ackPend = 1'b0;
            next_cur.sdaOe = 1'b0;
            next_cur.busBusy = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{
                state: lcd_pkg::ST_IDLE,
                bitCnt: 4'h0,
                rxShift: 8'h00,
                txShift: 8'h00,
                ackPend: 1'b0,
                rwBit: 1'b0,
                addrHit: 1'b0,
                sclLast: 1'b1,
                sdaLast: 1'b1,
                togLast: 1'b0,
                addrLsb: 1'b0,
                sdaOut: 1'b0,
                sdaOe: 1'b0,
                muxRate: lcd_pkg::lcd_mux_t'(`LCD_RST_MUX),
                dispStatus: lcd_pkg::lcd_disp_t'(`LCD_RST_DISP),
                systemType: 1'b0,
                topBank: 2'h0,
                subaddr: 4'h0,
                accessOrder: lcd_pkg::lcd_access_t'(`LCD_RST_ACCESS),
                ramBank: 2'h0,
                column: 6'h00,
                dataByte: 8'h00,
                dataStrobe: 1'b0,
                readStrobe: 1'b0,
                busBusy: 1'b0
            };
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    // open drain: the pin only ever pulls low
    assign sdaOut = cur.sdaOut;
    assign sdaOe = cur.sdaOe;
    assign muxRate = cur.muxRate;
    assign dispStatus = cur.dispStatus;
    assign systemType = cur.systemType;
    assign topBank = cur.topBank;
    assign subaddr = cur.subaddr;
    assign accessOrder = cur.accessOrder;
    assign ramBank = cur.ramBank;
    assign column = cur.column;
    assign dataByte = cur.dataByte;
    assign dataStrobe = cur.dataStrobe;
    assign readStrobe = cur.readStrobe;
    assign busBusy = cur.busBusy;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    mode_set_a: assert property (cmdEvt && curByte[6:5] == `LCD_OP_MODE |=>
        {systemType, dispStatus, muxRate} == $past(curByte[4:0]))
        else $error("set mode fields not loaded");

    bank_load_a: assert property (cmdEvt && lcd_is_bank(curByte) |=>
        topBank == $past(curByte[1:0]) && $stable(accessOrder) && $stable(ramBank))
        else $error("start bank load wrong or access fields touched");

    access_load_a: assert property (cmdEvt && !lcd_is_bank(curByte) && curByte[6:4] == `LCD_OP_ACCESS |=>
        accessOrder == $past(curByte[3:2]) && ramBank == $past(curByte[1:0]))
        else $error("ram access fields not loaded");

    subaddr_load_a: assert property (cmdEvt && curByte[6:4] == `LCD_OP_DEVSEL |=>
        subaddr == $past(curByte[3:0]) && $stable(topBank))
        else $error("subaddress not loaded");

    column_load_a: assert property (cmdEvt && !curByte[6] |=>
        column == (($past(curByte[5:0]) <= `LCD_MAX_COLUMN) ? $past(curByte[5:0]) : $past(column)))
        else $error("column pointer wrong");

    start_seen_a: assert property (startEvt |=> cur.state == lcd_pkg::ST_ADDR && cur.bitCnt == 4'h0 && busBusy)
        else $error("start not taken");

    stop_seen_a: assert property (stopEvt |=> cur.state == lcd_pkg::ST_IDLE && !sdaOe && !busBusy)
        else $error("stop not taken");

    drive_steady_a: assert property (sclLvl && cur.sclLast && !startEvt && !stopEvt |=> $stable(sdaOe))
        else $error("sda drive changed while scl high");

    ack_drive_a: assert property (sclFall && cur.bitCnt == `LCD_ACK_SLOT && cur.ackPend |=>
        sdaOe && !sdaOut)
        else $error("ack not driven low");

    cont_flag_a: assert property (cmdEvt && !curByte[`LCD_CONT_BIT] && !startEvt && !stopEvt |=>
        cur.state == lcd_pkg::ST_DATA)
        else $error("data phase not entered");

    store_gate_a: assert property (dataStrobe |-> systemType && subaddr == `LCD_HW_SUBADDR &&
        $past(cur.state) == lcd_pkg::ST_DATA)
        else $error("data stored for another subaddress");

    addr_miss_a: assert property (byteDone && cur.state == lcd_pkg::ST_ADDR &&
        curByte[7:1] != {`LCD_ADDR_HI, cur.addrLsb} |=> !cur.ackPend)
        else $error("foreign address acknowledged");

    nack_end_a: assert property (ackSample && cur.state == lcd_pkg::ST_READ && sampleBit && !stopEvt && !startEvt |=>
        cur.state == lcd_pkg::ST_SKIP ##1 !readStrobe)
        else $error("nack did not end the read");

    read_quiet_a: assert property (cur.state == lcd_pkg::ST_READ |=> $stable(muxRate) && $stable(column))
        else $error("configuration changed during a read");

    mode_cmd_c: cover property (cmdEvt && curByte[6:5] == `LCD_OP_MODE);
    data_store_c: cover property (dataStrobe);
    read_byte_c: cover property (readStrobe ##[1:1000] readStrobe);
    stop_frame_c: cover property (startEvt ##[1:1000] stopEvt);

endmodule : lcd_cmd_decoder

`default_nettype wire

// [sim/lcd_bus_master.sv]
`default_nettype none

// serial bus master; clock stands still high between frames
module lcd_bus_master (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 240;

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // start from idle or repeated start
    task automatic start();
        sdaLow = 1'b0;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : start

    task automatic stop();
        sdaLow = 1'b1;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b0;
        #Q;
    endtask : stop

    // data changes only while scl is low
    task automatic bitx(input logic b, output logic r);
        sdaLow = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bitx

    // eight bits msb first, then released ack slot
    task automatic wr(input logic [7:0] d, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        acked = (r === 1'b0);
    endtask : wr

    // ack every byte but the last
    task automatic rd(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(!ackIt, r);
    endtask : rd
endmodule : lcd_bus_master

`default_nettype wire

// [sim/test_lcd_cmd_decoder.sv]
`default_nettype none

module test_lcd_cmd_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0, rst_n = 1'b0, strap = 1'b0, a, sclW, sdaLow;
    logic [7:0] readByte = 8'h00, got, d;
    wire logic sdaOut, sdaOe, systemType, dataStrobe, readStrobe, busBusy;
    wire logic [1:0] muxRate, dispStatus, topBank, accessOrder, ramBank;
    wire logic [3:0] subaddr;
    wire logic [5:0] column;
    wire logic [7:0] dataByte;
    // open drain with pull-up: released line reads high
    wire logic sda = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
    wire logic [20:0] cfgNow = {muxRate, dispStatus, systemType, topBank, subaddr, accessOrder, ramBank, column};
    logic [1:0] eMux = 2'h0, eDisp = 2'h0, eBank = 2'h0, eAcc = 2'h0, eRb = 2'h0;
    logic eT = 1'b0;
    logic [3:0] eSub = 4'h0;
    logic [5:0] eCol = 6'h00;
    logic [20:0] q[$];
    logic [7:0] dq[$];
    int fails = 0, checked = 0, seed = 32'hc33b;
    event noteEv;

    always #10 mclk = ~mclk;

    lcd_bus_master i_lcd_bus_master (.scl(sclW), .sdaLow(sdaLow), .sda(sda));

    lcd_cmd_decoder i_lcd_cmd_decoder (.mclk(mclk), .rst_n(rst_n), .sclClk(sclW), .sclIn(sclW), .sdaIn(sda),
        .slaveAddrStrap(strap), .readByte(readByte), .sdaOut(sdaOut), .sdaOe(sdaOe), .muxRate(muxRate),
        .dispStatus(dispStatus), .systemType(systemType), .topBank(topBank), .subaddr(subaddr),
        .accessOrder(accessOrder), .ramBank(ramBank), .column(column), .dataByte(dataByte),
        .dataStrobe(dataStrobe), .readStrobe(readStrobe), .busBusy(busBusy));

    task automatic check(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : check

    task automatic stop_test();
        $display("counts: checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // expected decoder state, bank pattern tested before access
    task automatic model(input logic [7:0] b);
        if (b[6:5] == 2'b10) {eT, eDisp, eMux} = b[4:0];
        else if (b[6:2] == 5'h1f) eBank = b[1:0];
        else if (b[6:4] == 3'b110) eSub = b[3:0];
        else if (b[6:4] == 3'b111) {eAcc, eRb} = b[3:0];
        else if (!b[6] && b[5:0] <= 6'h27) eCol = b[5:0];
    endtask : model

    task automatic cmd(input logic [7:0] b);
        model(b);
        i_lcd_bus_master.wr(b, a);
        check(a, "command not acked");
        q.push_back({eMux, eDisp, eT, eBank, eSub, eAcc, eRb, eCol});
        ->noteEv;
    endtask : cmd

    task automatic frame(input logic [7:0] adr, input logic expAck);
        i_lcd_bus_master.start();
        check(busBusy === 1'b1, "busy after start");
        i_lcd_bus_master.wr(adr, a);
        check(a === expAck, "address ack");
    endtask : frame

    task automatic endFrame(input string n);
        i_lcd_bus_master.stop();
        check(busBusy === 1'b0, "busy after stop");
        $display("test %s done", n);
    endtask : endFrame

    always @(noteEv) check(cfgNow === q.pop_front(), "config outputs");

    always @(negedge mclk) if (dataStrobe === 1'b1) check(dq.size() > 0 && dataByte === dq.pop_front(), "data");

    initial begin
        #1_000_000;
        fails++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        strap <= 1'($random(seed));
        repeat (8) @(posedge mclk);
        frame({7'h3c | strap, 1'b0}, 1'b1);
        // continuation set on every command up to 8'h05, which clears it so data bytes follow
        for (int i = 0; i < 4; i++) cmd({3'b110, 1'($random(seed)), i[1:0], 2'(3 - i)});
        for (int i = 0; i < 4; i++) cmd({6'h3f, i[1:0]});
        cmd({4'he, 4'($random(seed))});
        for (int i = 0; i < 3; i++) cmd({4'hf, i[1:0], 2'($random(seed))});
        cmd({2'b10, 6'($unsigned($random(seed)) % 40)});
        cmd({2'b10, 6'(40 + $unsigned($random(seed)) % 24)});
        cmd(8'he0);
        cmd(8'hd0);
        cmd(8'h05);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            dq.push_back(d);
            i_lcd_bus_master.wr(d, a);
            check(a === 1'b1, "data ack");
        end
        endFrame("write");
        frame({7'h3c | strap, 1'b0}, 1'b1);
        cmd(8'h63);
        i_lcd_bus_master.wr(8'ha5, a);
        check(a === 1'b0, "foreign data acked");
        endFrame("subaddr");
        frame({7'h3c | !strap, 1'b0}, 1'b0);
        endFrame("address");
        @(posedge mclk) readByte <= 8'($random(seed));
        frame({7'h3c | strap, 1'b1}, 1'b1);
        i_lcd_bus_master.rd(1'b1, got);
        check(got === readByte, "read byte");
        i_lcd_bus_master.rd(1'b0, got);
        check(got === readByte && sda === 1'b1, "last read byte");
        endFrame("read");
        stop_test();
    end
endmodule : test_lcd_cmd_decoder

`default_nettype wire
